// ===== include/snoop_pkg.sv
`default_nettype none
// ==========================================================================
// Snooping control constants
package snoop_pkg;

  // ========================================================================
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_ENTRY_ATTR = 8'h77;
  localparam logic [7:0] IDX_IGMP_CTRL = 8'h78;
  localparam logic [7:0] IDX_PRIO_ROUTER = 8'h79;
  localparam logic [7:0] IDX_QUERY = 8'h7a;
  localparam logic [7:0] IDX_ROBUST = 8'h7b;
  localparam logic [7:0] IDX_MLD_CTRL = 8'h7c;
  localparam logic [31:0] ADDR_ENTRY_ATTR = {24'h00_0000, IDX_ENTRY_ATTR} << 2;
  localparam logic [31:0] ADDR_IGMP_CTRL = {24'h00_0000, IDX_IGMP_CTRL} << 2;
  localparam logic [31:0] ADDR_PRIO_ROUTER = {24'h00_0000, IDX_PRIO_ROUTER} << 2;
  localparam logic [31:0] ADDR_QUERY = {24'h00_0000, IDX_QUERY} << 2;
  localparam logic [31:0] ADDR_ROBUST = {24'h00_0000, IDX_ROBUST} << 2;
  localparam logic [31:0] ADDR_MLD_CTRL = {24'h00_0000, IDX_MLD_CTRL} << 2;

  // ========================================================================
  // Field positions
  localparam int FLAG_BIT = 5;
  localparam int STATIC_BIT = 4;
  localparam int PORT_HI = 3;
  localparam int PORT_LO = 0;
  localparam int UPORT_HI = 1;
  localparam int UGA_HI = 6;
  localparam int UGA_LO = 5;
  localparam int URM_BIT = 4;
  localparam int SWCPU_BIT = 3;
  localparam int HWCOPY_BIT = 2;
  localparam int SWMODE_BIT = 1;
  localparam int EN_BIT = 0;
  localparam int PE_BIT = 7;
  localparam int Q_HI = 6;
  localparam int Q_LO = 5;
  localparam int TAG_HI = 4;
  localparam int TAG_LO = 3;
  localparam int RPM_HI = 2;
  localparam int RPM_LO = 0;
  localparam int QINT_HI = 7;
  localparam int QINT_LO = 0;
  localparam int ROB_HI = 1;
  localparam int ROB_LO = 0;
  localparam int MLDCPU_BIT = 1;
  localparam int MLDEN_BIT = 0;

  // ========================================================================
  // Reset values and codes
  localparam logic [1:0] ROB_RESET = 2'h2;
  localparam logic [1:0] ROB_RESERVED = 2'h0;
  localparam logic [1:0] TAG_UNMODIFIED = 2'h0;
  localparam logic [1:0] TAG_RESERVED = 2'h3;
  localparam logic [1:0] QUEUE_NONE = 2'h0;
  localparam logic [1:0] UGA_RESET = 2'h0;
  localparam logic [2:0] RPM_RESET = 3'h0;
  localparam logic [7:0] QINT_RESET = 8'h00;
  localparam logic [3:0] PORT_RESET = 4'h0;
  localparam logic [1:0] UPORT_PAD = 2'h0;
  localparam logic [1:0] TBL_UCAST = 2'h0;
  localparam logic [1:0] TBL_MCAST = 2'h1;
  localparam logic [1:0] TBL_IGMP = 2'h2;
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_DELETE = 2'h2;

  // ========================================================================
  // Bus constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } bus_state_t;

endpackage : snoop_pkg
`default_nettype wire

// ===== hdl/ahb_reg_port.sv
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_port
  import snoop_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic reg_wr,
  output logic [31:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata
);
  bus_state_t state_r;
  logic write_r;
  logic size_ok_r;

  // ========================================================================
  // Address phase capture, one wait state so read data comes from a flop
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_r <= BUS_IDLE;
      hreadyout <= 1'b1;
      reg_addr <= WORD_ZERO;
      write_r <= 1'b0;
      size_ok_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        BUS_IDLE:
        begin
          if (hsel && htrans == HTRANS_NONSEQ && hready)
          begin
            state_r <= BUS_DATA;
            hreadyout <= 1'b0;
            reg_addr <= haddr;
            write_r <= hwrite;
            size_ok_r <= (hsize == HSIZE_WORD);
          end
        end
        BUS_DATA:
        begin
          state_r <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // ========================================================================
  // Data phase: write strobe raised on the same edge that samples the data
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      reg_wr <= 1'b0;
      reg_wdata <= WORD_ZERO;
    end
    else
    begin
      reg_wr <= (state_r == BUS_DATA) && write_r && size_ok_r;
      if (state_r == BUS_DATA)
      begin
        reg_wdata <= hwdata;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      hrdata <= WORD_ZERO;
      hresp <= HRESP_OKAY;
    end
    else
    begin
      hresp <= HRESP_OKAY;
      if (state_r == BUS_DATA && !write_r)
      begin
        hrdata <= reg_rdata;
      end
    end
  end

endmodule : ahb_reg_port
`default_nettype wire

// ===== hdl/snoop_ctrl.sv
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Entry flag reports IGMP-learned multicast entries
// - Static bit marks entries that never age
// - Port field: unicast number, multicast bitmap
// - Two-bit action for unknown multicast groups
// - Router map learned automatically unless user-defined
// - Software mode may send IGMP only to CPU
// - Hardware mode may copy IGMP to CPU
// - Bit0 enables snooping, bit1 selects software mode
// - Priority enable picks control packet queue
// - Two-bit egress tag mode, reserved code unmodified
// - Router map software-writable only when user-defined
// - Eight-bit query interval for hardware snooping
// - Robustness count 1 to 3, default 2
// - MLD snooping enable and CPU-only forwarding
// - IGMP table is read-only for commands
module snoop_ctrl
  import snoop_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic router_map_learn_valid,
  input wire logic [2:0] router_map_learn,
  input wire logic [1:0] table_select,
  input wire logic tbl_rd_valid,
  input wire logic tbl_rd_snooped,
  input wire logic tbl_rd_static,
  input wire logic [3:0] tbl_rd_port,
  input wire logic tbl_cmd_valid,
  input wire logic [1:0] tbl_cmd_code,
  output logic tbl_cmd_go,
  output logic [1:0] tbl_cmd_code_out,
  output logic tbl_cmd_refused,
  output logic entry_never_ages,
  output logic [3:0] tbl_wr_port,
  output logic snooping_enable,
  output logic software_mode_select,
  output logic [1:0] unknown_group_action,
  output logic igmp_cpu_only,
  output logic igmp_cpu_copy,
  output logic ctrl_pkt_prio_enable,
  output logic [1:0] ctrl_pkt_queue,
  output logic [1:0] ctrl_pkt_tag_mode,
  output logic [2:0] router_port_map,
  output logic [7:0] query_interval,
  output logic [1:0] robustness_count,
  output logic mld_snooping_enable,
  output logic mld_to_cpu_only
);
  logic reg_wr;
  logic [31:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] rdata_nxt;
  logic wr_attr;
  logic wr_ctrl;
  logic wr_prio;
  logic wr_query;
  logic wr_robust;
  logic wr_mld;

  logic snooped_entry_flag_r;
  logic [3:0] entry_port_r;
  logic [1:0] unknown_group_action_r;
  logic user_router_map_enable_r;
  logic sw_mode_cpu_only_r;
  logic hw_mode_cpu_copy_r;
  logic ctrl_pkt_prio_enable_r;
  logic [1:0] ctrl_pkt_queue_r;
  logic [1:0] ctrl_pkt_tag_mode_r;

  // ========================================================================
  // Bus slave
  ahb_reg_port i_ahb_reg_port (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(rdata_nxt)
  );

  // Unmapped addresses fall through: no strobe, read as zero
  assign wr_attr = reg_wr && (reg_addr == ADDR_ENTRY_ATTR);
  assign wr_ctrl = reg_wr && (reg_addr == ADDR_IGMP_CTRL);
  assign wr_prio = reg_wr && (reg_addr == ADDR_PRIO_ROUTER);
  assign wr_query = reg_wr && (reg_addr == ADDR_QUERY);
  assign wr_robust = reg_wr && (reg_addr == ADDR_ROBUST);
  assign wr_mld = reg_wr && (reg_addr == ADDR_MLD_CTRL);

  // ========================================================================
  // Entry attributes
  // Table read result wins over a software write in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      snooped_entry_flag_r <= 1'b0;
      entry_never_ages <= 1'b0;
      entry_port_r <= PORT_RESET;
    end
    else if (tbl_rd_valid)
    begin
      snooped_entry_flag_r <= (table_select == TBL_MCAST) && tbl_rd_snooped;
      entry_never_ages <= (table_select == TBL_UCAST) && tbl_rd_static;
      if (table_select == TBL_UCAST)
      begin
        entry_port_r <= {UPORT_PAD, tbl_rd_port[UPORT_HI:PORT_LO]};
      end
      else
      begin
        entry_port_r <= tbl_rd_port;
      end
    end
    else if (wr_attr)
    begin
      entry_never_ages <= reg_wdata[STATIC_BIT];
      entry_port_r <= reg_wdata[PORT_HI:PORT_LO];
    end
  end

  // Unicast writes carry only a port number 0..3
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      tbl_wr_port <= PORT_RESET;
    end
    else if (table_select == TBL_UCAST)
    begin
      tbl_wr_port <= {UPORT_PAD, entry_port_r[UPORT_HI:PORT_LO]};
    end
    else
    begin
      tbl_wr_port <= entry_port_r;
    end
  end

  // ========================================================================
  // Table command gate
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      tbl_cmd_go <= 1'b0;
      tbl_cmd_refused <= 1'b0;
      tbl_cmd_code_out <= CMD_READ;
    end
    else
    begin
      tbl_cmd_go <= 1'b0;
      tbl_cmd_refused <= 1'b0;
      if (tbl_cmd_valid)
      begin
        if (table_select == TBL_IGMP &&
            (tbl_cmd_code == CMD_WRITE || tbl_cmd_code == CMD_DELETE))
        begin
          tbl_cmd_refused <= 1'b1;
        end
        else
        begin
          tbl_cmd_go <= 1'b1;
          tbl_cmd_code_out <= tbl_cmd_code;
        end
      end
    end
  end

  // ========================================================================
  // IGMP snooping control
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      unknown_group_action_r <= UGA_RESET;
      user_router_map_enable_r <= 1'b0;
      sw_mode_cpu_only_r <= 1'b0;
      hw_mode_cpu_copy_r <= 1'b0;
      software_mode_select <= 1'b0;
      snooping_enable <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      unknown_group_action_r <= reg_wdata[UGA_HI:UGA_LO];
      user_router_map_enable_r <= reg_wdata[URM_BIT];
      sw_mode_cpu_only_r <= reg_wdata[SWCPU_BIT];
      hw_mode_cpu_copy_r <= reg_wdata[HWCOPY_BIT];
      software_mode_select <= reg_wdata[SWMODE_BIT];
      snooping_enable <= reg_wdata[EN_BIT];
    end
  end

  // Forwarding decisions lag the register by one cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      unknown_group_action <= UGA_RESET;
      igmp_cpu_only <= 1'b0;
      igmp_cpu_copy <= 1'b0;
    end
    else
    begin
      unknown_group_action <= unknown_group_action_r;
      igmp_cpu_only <= snooping_enable && software_mode_select && sw_mode_cpu_only_r;
      igmp_cpu_copy <= snooping_enable && !software_mode_select && hw_mode_cpu_copy_r;
    end
  end

  // ========================================================================
  // Control packet priority, tagging and router map
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ctrl_pkt_prio_enable_r <= 1'b0;
      ctrl_pkt_queue_r <= QUEUE_NONE;
      ctrl_pkt_tag_mode_r <= TAG_UNMODIFIED;
    end
    else if (wr_prio)
    begin
      ctrl_pkt_prio_enable_r <= reg_wdata[PE_BIT];
      ctrl_pkt_queue_r <= reg_wdata[Q_HI:Q_LO];
      ctrl_pkt_tag_mode_r <= reg_wdata[TAG_HI:TAG_LO];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ctrl_pkt_prio_enable <= 1'b0;
      ctrl_pkt_queue <= QUEUE_NONE;
      ctrl_pkt_tag_mode <= TAG_UNMODIFIED;
    end
    else
    begin
      ctrl_pkt_prio_enable <= ctrl_pkt_prio_enable_r;
      ctrl_pkt_queue <= ctrl_pkt_prio_enable_r ? ctrl_pkt_queue_r : QUEUE_NONE;
      // Reserved tag code is never passed on to egress
      ctrl_pkt_tag_mode <= (ctrl_pkt_tag_mode_r == TAG_RESERVED) ?
                           TAG_UNMODIFIED : ctrl_pkt_tag_mode_r;
    end
  end

  // Learned updates are dropped while the map is user-defined
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      router_port_map <= RPM_RESET;
    end
    else if (user_router_map_enable_r)
    begin
      if (wr_prio)
      begin
        router_port_map <= reg_wdata[RPM_HI:RPM_LO];
      end
    end
    else if (router_map_learn_valid)
    begin
      router_port_map <= router_map_learn;
    end
  end

  // ========================================================================
  // Query interval, robustness, MLD
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      query_interval <= QINT_RESET;
    end
    else if (wr_query)
    begin
      query_interval <= reg_wdata[QINT_HI:QINT_LO];
    end
  end

  // Reserved code is refused so the count is never zero
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      robustness_count <= ROB_RESET;
    end
    else if (wr_robust && reg_wdata[ROB_HI:ROB_LO] != ROB_RESERVED)
    begin
      robustness_count <= reg_wdata[ROB_HI:ROB_LO];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mld_snooping_enable <= 1'b0;
      mld_to_cpu_only <= 1'b0;
    end
    else if (wr_mld)
    begin
      mld_snooping_enable <= reg_wdata[MLDEN_BIT];
      mld_to_cpu_only <= reg_wdata[MLDCPU_BIT];
    end
  end

  // ========================================================================
  // Read mux, reserved bits stay zero
  always_comb
  begin
    rdata_nxt = WORD_ZERO;
    case (reg_addr)
      ADDR_ENTRY_ATTR:
      begin
        rdata_nxt[FLAG_BIT] = snooped_entry_flag_r;
        rdata_nxt[STATIC_BIT] = entry_never_ages;
        rdata_nxt[PORT_HI:PORT_LO] = entry_port_r;
      end
      ADDR_IGMP_CTRL:
      begin
        rdata_nxt[UGA_HI:UGA_LO] = unknown_group_action_r;
        rdata_nxt[URM_BIT] = user_router_map_enable_r;
        rdata_nxt[SWCPU_BIT] = sw_mode_cpu_only_r;
        rdata_nxt[HWCOPY_BIT] = hw_mode_cpu_copy_r;
        rdata_nxt[SWMODE_BIT] = software_mode_select;
        rdata_nxt[EN_BIT] = snooping_enable;
      end
      ADDR_PRIO_ROUTER:
      begin
        rdata_nxt[PE_BIT] = ctrl_pkt_prio_enable_r;
        rdata_nxt[Q_HI:Q_LO] = ctrl_pkt_queue_r;
        rdata_nxt[TAG_HI:TAG_LO] = ctrl_pkt_tag_mode_r;
        rdata_nxt[RPM_HI:RPM_LO] = router_port_map;
      end
      ADDR_QUERY:
      begin
        rdata_nxt[QINT_HI:QINT_LO] = query_interval;
      end
      ADDR_ROBUST:
      begin
        rdata_nxt[ROB_HI:ROB_LO] = robustness_count;
      end
      ADDR_MLD_CTRL:
      begin
        rdata_nxt[MLDCPU_BIT] = mld_to_cpu_only;
        rdata_nxt[MLDEN_BIT] = mld_snooping_enable;
      end
      default:
      begin
        rdata_nxt = WORD_ZERO;
      end
    endcase
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_router_sw_ignored: assert property (
    !user_router_map_enable_r && wr_prio && !router_map_learn_valid
    |=> $stable(router_port_map))
    else $error("router map changed by write in automatic mode");

  a_router_learn_taken: assert property (
    !user_router_map_enable_r && router_map_learn_valid
    |=> router_port_map == $past(router_map_learn))
    else $error("learned router map not taken");

  a_igmp_table_locked: assert property (
    tbl_cmd_valid && table_select == TBL_IGMP && tbl_cmd_code == CMD_DELETE
    |=> tbl_cmd_refused && !tbl_cmd_go)
    else $error("delete on membership table not refused");

  a_cpu_only_mode: assert property (
    igmp_cpu_only |-> $past(software_mode_select) && $past(snooping_enable))
    else $error("cpu only outside software mode");

  a_cpu_copy_mode: assert property (
    wr_ctrl && reg_wdata[EN_BIT] && reg_wdata[HWCOPY_BIT] && !reg_wdata[SWMODE_BIT]
    |=> ##1 igmp_cpu_copy)
    else $error("hardware copy to cpu not raised");

  a_robust_nonzero: assert property (
    robustness_count != ROB_RESERVED)
    else $error("robustness count reserved");

  a_unicast_port_range: assert property (
    table_select == TBL_UCAST |=> tbl_wr_port[PORT_HI:UPORT_HI + 1] == UPORT_PAD)
    else $error("unicast port out of range");

  a_snoop_flag_ucast: assert property (
    tbl_rd_valid && table_select == TBL_UCAST |=> !snooped_entry_flag_r)
    else $error("igmp flag set on unicast entry");

  a_queue_gated: assert property (
    !ctrl_pkt_prio_enable_r |=> ctrl_pkt_queue == QUEUE_NONE)
    else $error("queue given while priority disabled");

  a_tag_reserved: assert property (
    ctrl_pkt_tag_mode != TAG_RESERVED)
    else $error("reserved tag mode reached egress");

  a_bus_one_wait: assert property (
    hsel && htrans == HTRANS_NONSEQ && hready && hreadyout
    |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not one wait state");

endmodule : snoop_ctrl
`default_nettype wire

// ===== verification/igmp_mld_snooping_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module igmp_mld_snooping_control_test
  import snoop_pkg::*;
;
  // ====================================
  // Stimulus and observed signals
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] haddr = WORD_ZERO;
  logic [31:0] hwdata = WORD_ZERO;
  logic router_map_learn_valid = 1'b0;
  logic [2:0] router_map_learn = 3'h0;
  logic [1:0] table_select = 2'h0;
  logic tbl_rd_valid = 1'b0, tbl_rd_snooped = 1'b0, tbl_rd_static = 1'b0;
  logic [3:0] tbl_rd_port = 4'h0;
  logic tbl_cmd_valid = 1'b0;
  logic [1:0] tbl_cmd_code = 2'h0;
  logic hreadyout, hresp, tbl_cmd_go, tbl_cmd_refused, entry_never_ages;
  logic snooping_enable, software_mode_select, igmp_cpu_only, igmp_cpu_copy;
  logic ctrl_pkt_prio_enable, mld_snooping_enable, mld_to_cpu_only;
  logic [1:0] tbl_cmd_code_out, unknown_group_action, ctrl_pkt_queue;
  logic [1:0] ctrl_pkt_tag_mode, robustness_count;
  logic [2:0] router_port_map;
  logic [3:0] tbl_wr_port;
  logic [7:0] query_interval;
  logic [31:0] hrdata;
  int bad_count = 0;
  int check_count = 0;
  logic [31:0] rd_q[$];
  logic [3:0] cmd_q[$];
  logic rd_phase = 1'b0;

  always #2.5 sys_clk = ~sys_clk;

  snoop_ctrl i_snoop_ctrl (
    .sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .router_map_learn_valid,
    .router_map_learn, .table_select, .tbl_rd_valid, .tbl_rd_snooped, .tbl_rd_static,
    .tbl_rd_port, .tbl_cmd_valid, .tbl_cmd_code, .tbl_cmd_go, .tbl_cmd_code_out,
    .tbl_cmd_refused, .entry_never_ages, .tbl_wr_port, .snooping_enable,
    .software_mode_select, .unknown_group_action, .igmp_cpu_only, .igmp_cpu_copy,
    .ctrl_pkt_prio_enable, .ctrl_pkt_queue, .ctrl_pkt_tag_mode, .router_port_map,
    .query_interval, .robustness_count, .mld_snooping_enable, .mld_to_cpu_only
  );

  // ====================================
  // Comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // ====================================
  // Bus master, waits on ready with no fixed latency
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
      input logic [2:0] sz);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    htrans <= HTRANS_NONSEQ;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] u;
    u = $urandom;
    bus(1'b1, a, {u[31:8], d}, HSIZE_WORD);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    rd_q.push_back(32'(e));
    bus(1'b0, a, WORD_ZERO, HSIZE_WORD);
  endtask : rd

  // ====================================
  // Monitor: pops the oldest note when a result shows
  always @(posedge sys_clk)
  begin
    if (rd_phase && hreadyout === 1'b1)
    begin
      check(hrdata, rd_q.pop_front());
      check(32'(hresp), 32'(HRESP_OKAY));
      rd_phase = 1'b0;
    end
    if (hsel === 1'b1 && htrans === HTRANS_NONSEQ && hreadyout === 1'b1)
      rd_phase = !hwrite;
    if (tbl_cmd_go === 1'b1 || tbl_cmd_refused === 1'b1)
      check(32'({tbl_cmd_go, tbl_cmd_refused, tbl_cmd_go ? tbl_cmd_code_out : 2'h0}),
          32'(cmd_q.pop_front()));
  end

  // Hang guard, far beyond the few hundred cycles needed
  initial
  begin
    #100000;
    bad_count++;
    give_verdict();
  end

  // ====================================
  // Main sequence
  initial
  begin
    logic [7:0] a, p, q, r, m, l, e, rpm_exp, rv_exp;
    void'($urandom(2007));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(ADDR_IGMP_CTRL, 8'h00);
    rd(ADDR_PRIO_ROUTER, 8'h00);
    rd(ADDR_QUERY, 8'h00);
    rd(ADDR_ROBUST, 8'(ROB_RESET));
    rd(ADDR_MLD_CTRL, 8'h00);
    rd(ADDR_ENTRY_ATTR, 8'h00);
    rpm_exp = 8'h00;
    rv_exp = 8'(ROB_RESET);
    for (int i = 0; i < 10; i++)
    begin
      a = 8'($urandom);
      p = 8'($urandom);
      q = 8'($urandom);
      r = 8'($urandom);
      m = 8'($urandom);
      l = 8'($urandom);
      wr(ADDR_IGMP_CTRL, a);
      router_map_learn_valid <= 1'b1;
      router_map_learn <= l[2:0];
      @(posedge sys_clk);
      router_map_learn_valid <= 1'b0;
      if (!a[4])
        rpm_exp = 8'(l[2:0]);
      wr(ADDR_PRIO_ROUTER, p);
      if (a[4])
        rpm_exp = 8'(p[2:0]);
      wr(ADDR_QUERY, q);
      bus(1'b1, ADDR_QUERY, 32'(~q), 3'h0);
      wr(ADDR_ROBUST, r);
      if (r[1:0] != ROB_RESERVED)
        rv_exp = 8'(r[1:0]);
      wr(ADDR_MLD_CTRL, m);
      rd(ADDR_IGMP_CTRL, {1'b0, a[6:0]});
      rd(ADDR_PRIO_ROUTER, {p[7:3], rpm_exp[2:0]});
      rd(ADDR_QUERY, q);
      rd(ADDR_ROBUST, rv_exp);
      rd(ADDR_MLD_CTRL, {6'h00, m[1:0]});
      check(32'({software_mode_select, snooping_enable}), 32'(a[1:0]));
      check(32'(unknown_group_action), 32'(a[6:5]));
      check(32'(igmp_cpu_only), 32'(a[0] & a[1] & a[3]));
      check(32'(igmp_cpu_copy), 32'(a[0] & !a[1] & a[2]));
      check(32'({ctrl_pkt_prio_enable, ctrl_pkt_queue}), 32'({p[7], p[7] ? p[6:5] : QUEUE_NONE}));
      check(32'(ctrl_pkt_tag_mode), 32'((p[4:3] == TAG_RESERVED) ? TAG_UNMODIFIED : p[4:3]));
      check(32'(router_port_map), 32'(rpm_exp[2:0]));
      check(32'(query_interval), 32'(q));
      check(32'(robustness_count), 32'(rv_exp[1:0]));
      check(32'({mld_to_cpu_only, mld_snooping_enable}), 32'(m[1:0]));
    end
    wr(ADDR_ROBUST, 8'h00);
    rd(ADDR_ROBUST, rv_exp);
    wr(32'h0000_0100, 8'hff);
    rd(32'h0000_0100, 8'h00);
    // Back-to-back commands on every table and code
    for (int t = 0; t < 3; t++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        table_select <= 2'(t);
        tbl_cmd_valid <= 1'b1;
        tbl_cmd_code <= 2'(c);
        cmd_q.push_back((t == 2 && (c == 1 || c == 2)) ? 4'h4 : {2'h2, 2'(c)});
        @(posedge sys_clk);
      end
    end
    tbl_cmd_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(32'(cmd_q.size()), WORD_ZERO);
    // Table read results per table kind
    for (int t = 0; t < 3; t++)
    begin
      l = 8'($urandom);
      table_select <= 2'(t);
      tbl_rd_snooped <= l[5];
      tbl_rd_static <= l[4];
      tbl_rd_port <= l[3:0];
      tbl_rd_valid <= 1'b1;
      @(posedge sys_clk);
      tbl_rd_valid <= 1'b0;
      e = {2'h0, l[5] & (t == 1), l[4] & (t == 0), (t == 0) ? {2'h0, l[1:0]} : l[3:0]};
      rd(ADDR_ENTRY_ATTR, e);
      check(32'({entry_never_ages, tbl_wr_port}), 32'(e[4:0]));
    end
    // Flag bit is read-only to software
    table_select <= TBL_MCAST;
    wr(ADDR_ENTRY_ATTR, 8'hff);
    rd(ADDR_ENTRY_ATTR, 8'h1f);
    check(32'({entry_never_ages, tbl_wr_port}), 32'h0000_001f);
    table_select <= TBL_UCAST;
    repeat (3) @(posedge sys_clk);
    check(32'(tbl_wr_port), 32'h0000_0003);
    // Second reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(ADDR_ROBUST, 8'(ROB_RESET));
    rd(ADDR_QUERY, 8'h00);
    rd(ADDR_IGMP_CTRL, 8'h00);
    give_verdict();
  end
endmodule : igmp_mld_snooping_control_test
`default_nettype wire
